// [include/dac_pkg.sv]
// Constants and carrier types for the octal converter control logic.
// Functional notes
// - Shift sixteen bits MSB first on falling clock.
// - Early frame select rise discards partial frame.
// - Bit 15 selects data write or control.
// - Bits 14 to 12 address channels A-H.
// - Strobe mode command 101, code in bits 1:0.
// - Code 00 keeps strobe asserted, outputs follow.
// - Code 01 latches outputs; default after reset.
// - Code 10 gives one single update pulse.
// - Power-down command powers down flagged channels.
// - Data reset clears input and output registers.
// - Full reset also restores all control settings.
// - Serial path enabled only between select edges.
// - Valid data frame loads addressed input register.
// - Pin high with code 01 keeps outputs latched.
// - Code 00 or pin low makes outputs transparent.
// - Synchronous update follows the 16th falling edge.
// - Asynchronous update on falling strobe pin edge.
// - Gain and reference settings are double-buffered.
// - Strobe updates only freshly written channels.
package dac_pkg;
  localparam int NCH = 8;
  localparam int DW = 12;
  localparam logic [4:0] BIT_CNT_LAST = 5'h0F;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [1:0] LD_LOW = 2'h0;
  localparam logic [1:0] LD_HIGH = 2'h1;
  localparam logic [1:0] LD_SINGLE = 2'h2;
  localparam logic [1:0] LD_RSVD = 2'h3;
  localparam logic [1:0] CM_REF = 2'h0;
  localparam logic [1:0] CM_STROBE = 2'h1;
  localparam logic [1:0] CM_PD = 2'h2;
  localparam logic [1:0] CM_RST = 2'h3;
  localparam logic [1:0] MODE_RESET = LD_HIGH;
  localparam logic [7:0] PD_RESET = 8'h00;
  localparam logic [5:0] REF_RESET = 6'h00;
  localparam logic CONFIG_RESET = 1'b1;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FRAMES = 8'h08;
  localparam logic [7:0] ADDR_CODE0 = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] bufr;
    logic [1:0] vdd;
  } ref_cfg_t;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } frame_t;
  typedef logic [DW-1:0] code_t;
  typedef logic [NCH-1:0][DW-1:0] code_bank_t;
endpackage

// [rtl/dac_channel_bank.sv]
// Double-buffered input and output register banks with fresh flags.
`timescale 1ns/1ps
module dac_channel_bank (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire dac_pkg::code_t i_data,
  input wire logic i_ref_wr,
  input wire dac_pkg::ref_cfg_t i_ref,
  input wire logic i_load,
  input wire logic i_clr_data,
  input wire logic i_clr_ref,
  output dac_pkg::code_bank_t o_code,
  output dac_pkg::ref_cfg_t o_ref,
  output logic [7:0] o_dirty
);
  dac_pkg::code_bank_t in_reg;
  dac_pkg::code_bank_t out_reg;
  logic [7:0] dirty_reg;
  dac_pkg::ref_cfg_t ref_in_reg;
  dac_pkg::ref_cfg_t ref_out_reg;
  logic ref_dirty_reg;
  wire [7:0] wr_hit = i_wr ? (8'h01 << i_addr) : 8'h00;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_clr_data) begin
      in_reg <= '0;
      out_reg <= '0;
      dirty_reg <= 8'h00;
    end else begin
      for (int i = 0; i < dac_pkg::NCH; i++) begin
        if (wr_hit[i]) begin
          in_reg[i] <= i_data;
        end
        if (i_load && dirty_reg[i]) begin
          out_reg[i] <= in_reg[i];
        end
      end
      dirty_reg <= wr_hit | (dirty_reg & ~{8{i_load}});
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_clr_ref) begin
      ref_in_reg <= dac_pkg::REF_RESET;
      ref_out_reg <= dac_pkg::REF_RESET;
      ref_dirty_reg <= 1'b0;
    end else begin
      if (i_ref_wr) begin
        ref_in_reg <= i_ref;
      end
      if (i_load && ref_dirty_reg) begin
        ref_out_reg <= ref_in_reg;
      end
      ref_dirty_reg <= i_ref_wr | (ref_dirty_reg & ~i_load);
    end
  end

  assign o_code = out_reg;
  assign o_ref = ref_out_reg;
  assign o_dirty = dirty_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_load_copy:
  assert property (i_load && dirty_reg[0] && !i_clr_data |=>
                   out_reg[0] == $past(in_reg[0]))
    else $error("Fresh channel not copied on strobe.");
  a_clean_hold:
  assert property (!dirty_reg[3] && !i_clr_data |=> $stable(out_reg[3]))
    else $error("Unwritten channel output changed.");
  a_ref_defer:
  assert property (!(i_load && ref_dirty_reg) && !i_clr_ref |=>
                   $stable(ref_out_reg))
    else $error("Reference settings changed without a strobe.");
  a_data_clear:
  assert property (i_clr_data |=> in_reg == '0 && out_reg == '0)
    else $error("Data reset left nonzero registers.");
endmodule

// [rtl/octal_dac_ctrl.sv]
// Top of the octal converter control logic with its bus slave.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module octal_dac_ctrl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_din,
  input wire logic i_load_strobe_n,
  output dac_pkg::code_bank_t o_dac_code,
  output dac_pkg::ref_cfg_t o_ref_cfg,
  output logic [7:0] o_power_down
);
  dac_pkg::frame_t frame;
  dac_pkg::code_bank_t code_out;
  dac_pkg::ref_cfg_t ref_out;
  logic [7:0] dirty;
  logic [1:0] ld_s_reg;
  logic [1:0] mode_reg;
  logic [7:0] pd_reg;
  logic single_reg;
  logic [15:0] frame_cnt_reg;
  logic config_reg;

  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Command decode of a completed frame.
  wire [15:0] cmd_word = frame.word;
  wire is_data = frame.valid & ~cmd_word[15];
  wire is_ctl = frame.valid & cmd_word[15];
  wire [1:0] ctl_mode = cmd_word[14:13];
  wire [1:0] ld_code = cmd_word[1:0];
  wire ld_sel = is_ctl & (ctl_mode == dac_pkg::CM_STROBE);
  wire mode_cmd = ld_sel & (ld_code != dac_pkg::LD_RSVD);
  wire single_cmd = mode_cmd & (ld_code == dac_pkg::LD_SINGLE);
  wire rsvd_cmd = ld_sel & (ld_code == dac_pkg::LD_RSVD);
  wire pd_cmd = is_ctl & (ctl_mode == dac_pkg::CM_PD);
  wire rst_cmd = is_ctl & (ctl_mode == dac_pkg::CM_RST);
  wire full_rst = rst_cmd & cmd_word[12];
  wire ref_cmd = is_ctl & (ctl_mode == dac_pkg::CM_REF);

  // Strobe generation from the mode code and the strobe pin.
  wire strobe_low = ~ld_s_reg[1];
  wire follow = (mode_reg == dac_pkg::LD_LOW) | strobe_low;
  wire load = follow | single_reg;

  serial_frame_rx u_rx (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(config_reg),
    .i_sclk(i_sclk),
    .i_sync_n(i_sync_n),
    .i_din(i_din),
    .o_frame(frame)
  );

  dac_channel_bank u_bank (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(is_data),
    .i_addr(cmd_word[14:12]),
    .i_data(cmd_word[11:0]),
    .i_ref_wr(ref_cmd),
    .i_ref(dac_pkg::ref_cfg_t'(cmd_word[5:0])),
    .i_load(load),
    .i_clr_data(rst_cmd),
    .i_clr_ref(full_rst),
    .o_code(code_out),
    .o_ref(ref_out),
    .o_dirty(dirty)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ld_s_reg <= 2'h3;
    end else begin
      ld_s_reg <= {ld_s_reg[0], i_load_strobe_n};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || full_rst) begin
      mode_reg <= dac_pkg::MODE_RESET;
      pd_reg <= dac_pkg::PD_RESET;
      single_reg <= 1'b0;
    end else begin
      if (mode_cmd) begin
        mode_reg <= ld_code;
      end
      single_reg <= single_cmd;
      if (pd_cmd) begin
        pd_reg <= cmd_word[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frame_cnt_reg <= 16'h0000;
    end else if (frame.valid) begin
      frame_cnt_reg <= frame_cnt_reg + 16'h0001;
    end
  end

  assign o_dac_code = code_out;
  assign o_ref_cfg = ref_out;
  assign o_power_down = pd_reg;

  // Write channel: address and data are taken in either order.
  wire aw_take = i_awvalid & awready_reg;
  wire w_take = i_wvalid & wready_reg;
  wire aw_have = aw_hold_reg | aw_take;
  wire w_have = w_hold_reg | w_take;
  wire do_wr = aw_have & w_have & ~bvalid_reg;
  wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : i_awaddr;
  wire [31:0] wr_data = w_hold_reg ? w_data_reg : i_wdata;
  wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : i_wstrb;
  wire wr_cfg = wr_addr == dac_pkg::ADDR_CONFIG;
  wire aw_hold_next = aw_have & ~do_wr;
  wire w_hold_next = w_have & ~do_wr;
  wire bvalid_next = do_wr | (bvalid_reg & ~i_bready);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dac_pkg::RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awready_reg <= ~aw_hold_next & ~bvalid_next;
      wready_reg <= ~w_hold_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_wr) begin
        bresp_reg <= wr_cfg ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= i_awaddr;
      end
      if (w_take) begin
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      config_reg <= dac_pkg::CONFIG_RESET;
    end else if (do_wr && wr_cfg && wr_strb[0]) begin
      config_reg <= wr_data[0];
    end
  end

  // Read channel: one register word per aligned address.
  wire ar_take = i_arvalid & arready_reg;
  wire [2:0] rd_ch = i_araddr[4:2];
  wire rd_code = (i_araddr[7:5] == dac_pkg::ADDR_CODE0[7:5]) &
                 (i_araddr[1:0] == 2'h0);
  wire rd_cfg = i_araddr == dac_pkg::ADDR_CONFIG;
  wire rd_stat = i_araddr == dac_pkg::ADDR_STATUS;
  wire rd_frm = i_araddr == dac_pkg::ADDR_FRAMES;
  wire rd_ok = rd_code | rd_cfg | rd_stat | rd_frm;
  wire [31:0] status_word = {8'h00, dirty, ref_out, pd_reg, mode_reg};
  wire [31:0] rd_value = rd_code ? {20'h00000, code_out[rd_ch]} :
                         rd_cfg ? {31'h00000000, config_reg} :
                         rd_stat ? status_word :
                         rd_frm ? {16'h0000, frame_cnt_reg} :
                         32'h00000000;
  wire rvalid_next = ar_take | (rvalid_reg & ~i_rready);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= dac_pkg::RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_value;
        rresp_reg <= rd_ok ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
      end
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_single_req;
    single_cmd;
  endsequence
  sequence s_one_pulse;
    load ##1 !single_reg;
  endsequence
  sequence s_read_done;
    rvalid_reg ##0 !arready_reg;
  endsequence

  a_single_pulse:
  assert property (s_single_req |=> s_one_pulse)
    else $error("Single update did not give exactly one strobe.");
  a_reserved_keep:
  assert property (rsvd_cmd |=> $stable(mode_reg))
    else $error("Reserved strobe code altered the mode.");
  a_latched_hold:
  assert property (mode_reg == dac_pkg::LD_HIGH && !strobe_low &&
                   !single_reg && !rst_cmd |=> $stable(code_out))
    else $error("Strobe raised while outputs latched.");
  a_follow_mode:
  assert property ((mode_reg == dac_pkg::LD_LOW || strobe_low) && !is_data
                   |=> dirty == 8'h00)
    else $error("Outputs not transparent when required.");
  a_pd_apply:
  assert property (pd_cmd |=> o_power_down == $past(cmd_word[7:0]))
    else $error("Power-down field not applied.");
  a_full_reset:
  assert property (full_rst |=> mode_reg == dac_pkg::MODE_RESET &&
                   pd_reg == dac_pkg::PD_RESET)
    else $error("Full reset left control settings.");
  a_no_partial:
  assert property (!frame.valid |=> $stable(mode_reg) && $stable(pd_reg))
    else $error("Settings changed without a complete frame.");
  a_write_answer:
  assert property (do_wr |=> bvalid_reg [*1] ##0 !awready_reg)
    else $error("Write answer missing after accepted write.");
  a_read_answer:
  assert property (ar_take |=> s_read_done)
    else $error("Read answer missing after accepted address.");
  a_bresp_hold:
  assert property (bvalid_reg && !i_bready |=> bvalid_reg &&
                   $stable(bresp_reg))
    else $error("Write response dropped before it was taken.");
  a_rdata_hold:
  assert property (rvalid_reg && !i_rready |=> rvalid_reg &&
                   $stable(rdata_reg) && $stable(rresp_reg))
    else $error("Read data changed before it was taken.");
  a_data_route:
  assert property (is_data |=> dirty[$past(cmd_word[14:12])])
    else $error("Data frame did not mark its channel.");
  a_mode_store:
  assert property (mode_cmd |=> mode_reg == $past(ld_code))
    else $error("Strobe mode command not stored.");
  a_frame_count:
  assert property (frame.valid |=> frame_cnt_reg ==
                   $past(frame_cnt_reg) + 16'h0001)
    else $error("Completed frame not counted.");
  a_data_reset:
  assert property (rst_cmd |=> dirty == 8'h00)
    else $error("Data reset left channels marked fresh.");
  a_cfg_write:
  assert property (do_wr && wr_cfg && wr_strb[0] |=>
                   config_reg == $past(wr_data[0]))
    else $error("Serial enable write not applied.");
endmodule

// [rtl/serial_frame_rx.sv]
// Serial frame receiver with pin synchronisers and select gating.
`timescale 1ns/1ps
module serial_frame_rx (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_din,
  output dac_pkg::frame_t o_frame
);
  logic [1:0] sclk_s_reg;
  logic [1:0] sync_s_reg;
  logic [1:0] din_s_reg;
  logic sclk_d_reg;
  logic sync_d_reg;
  logic active_reg;
  logic [4:0] cnt_reg;
  logic [15:0] shift_reg;
  dac_pkg::frame_t frame_reg;
  wire sclk_fall = sclk_d_reg & ~sclk_s_reg[1];
  wire sync_fall = sync_d_reg & ~sync_s_reg[1];
  wire sync_high = sync_s_reg[1];
  wire bit_take = active_reg & ~sync_high & sclk_fall &
                  (cnt_reg < dac_pkg::BIT_CNT_FULL);
  wire last_bit = bit_take & (cnt_reg == dac_pkg::BIT_CNT_LAST);
  wire [15:0] shift_next = {shift_reg[14:0], din_s_reg[1]};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_s_reg <= 2'h0;
      sync_s_reg <= 2'h3;
      din_s_reg <= 2'h0;
      sclk_d_reg <= 1'b0;
      sync_d_reg <= 1'b1;
    end else begin
      sclk_s_reg <= {sclk_s_reg[0], i_sclk};
      sync_s_reg <= {sync_s_reg[0], i_sync_n};
      din_s_reg <= {din_s_reg[0], i_din};
      sclk_d_reg <= sclk_s_reg[1];
      sync_d_reg <= sync_s_reg[1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || sync_high) begin
      active_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else begin
      if (sync_fall && i_enable) begin
        active_reg <= 1'b1;
      end
      if (bit_take) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      shift_reg <= 16'h0000;
      frame_reg <= '0;
    end else begin
      if (bit_take) begin
        shift_reg <= shift_next;
      end
      frame_reg.valid <= last_bit;
      if (last_bit) begin
        frame_reg.word <= shift_next;
      end
    end
  end

  assign o_frame = frame_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_frame_sixteen:
  assert property (frame_reg.valid |-> $past(sclk_fall) &&
                   $past(cnt_reg) == dac_pkg::BIT_CNT_LAST)
    else $error("Frame ended without sixteen bits.");
  a_abort_drop:
  assert property (sync_high |=> !frame_reg.valid)
    else $error("Frame completed after select returned high.");
  a_idle_gate:
  assert property (!active_reg |=> $stable(shift_reg))
    else $error("Shift register moved while interface idle.");
endmodule

// [verification/serial_host_model.sv]
// Host serial port model driving the three-wire frame link.
`timescale 1ns/1ps
module serial_host_model (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_din
);
  initial begin
    o_sclk = 1'b0;
    o_sync_n = 1'b1;
    o_din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Sends nbits of a word, with an optional pause after the first byte.
  task automatic send(input logic [15:0] w, input int nbits,
                      input int gap);
    o_sync_n <= 1'b0;
    tick(4);
    for (int i = 15; i > 15 - nbits; i--) begin
      o_din <= w[i];
      o_sclk <= 1'b1;
      tick(4);
      o_sclk <= 1'b0;
      tick(4);
      if (i == 8) tick(gap);
    end
    tick(2);
    o_sync_n <= 1'b1;
    o_din <= ~o_din;
    tick(6);
  endtask
  // Stray clock pulses while the device is deselected.
  task automatic stray(input int n);
    repeat (n) begin
      o_sclk <= 1'b1;
      o_din <= ~o_din;
      tick(4);
      o_sclk <= 1'b0;
      tick(4);
    end
  endtask
endmodule

// [verification/test_octal_dac_command_and_update_logic.sv]
// Self-checking bench for the octal converter control top.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module test_octal_dac_command_and_update_logic;
  logic i_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready;
  logic i_arvalid, i_rready, o_awready, o_wready, o_bvalid;
  logic o_arready, o_rvalid, i_sclk, i_sync_n, i_din, i_load_strobe_n;
  logic [7:0] i_awaddr, i_araddr, o_power_down, dirty, pd;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rsp, mode;
  dac_pkg::code_bank_t o_dac_code;
  dac_pkg::ref_cfg_t o_ref_cfg;
  logic [11:0] inp [8];
  logic [11:0] outr [8];
  logic [5:0] rstg, rapp;
  logic pin_low;
  logic [1:0] codes [4];
  int err_count, comparisons, nfr;

  octal_dac_ctrl i_dut (.i_clk, .i_sys_rst, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_sclk, .i_sync_n, .i_din,
    .i_load_strobe_n, .o_dac_code, .o_ref_cfg, .o_power_down);
  serial_host_model i_host (.i_clk, .o_sclk(i_sclk),
    .o_sync_n(i_sync_n), .o_din(i_din));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    repeat (50) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        r = o_bresp;
        i_bready <= 1'b0;
        return;
      end
    end
    `CHK(1'b0, 1'b1)
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    repeat (50) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        return;
      end
    end
    `CHK(1'b0, 1'b1)
  endtask

  function automatic void m_load();
    for (int c = 0; c < 8; c++) begin
      if (dirty[c]) outr[c] = inp[c];
    end
    dirty = 8'h00;
    rapp = rstg;
  endfunction

  function automatic void m_apply(input logic [15:0] w);
    if (!w[15]) begin
      inp[w[14:12]] = w[11:0];
      dirty[w[14:12]] = 1'b1;
    end else if (w[14:13] == dac_pkg::CM_REF) begin
      rstg = w[5:0];
    end else if (w[14:13] == dac_pkg::CM_STROBE) begin
      if (w[1:0] != dac_pkg::LD_RSVD) mode = w[1:0];
      if (w[1:0] == dac_pkg::LD_SINGLE) m_load();
    end else if (w[14:13] == dac_pkg::CM_PD) begin
      pd = w[7:0];
    end else begin
      for (int c = 0; c < 8; c++) begin
        inp[c] = 12'h000;
        outr[c] = 12'h000;
      end
      dirty = 8'h00;
      if (w[12]) begin
        mode = dac_pkg::LD_HIGH;
        pd = 8'h00;
        rstg = 6'h00;
        rapp = 6'h00;
      end
    end
    if (mode == dac_pkg::LD_LOW || pin_low) m_load();
  endfunction

  task automatic frame(input logic [15:0] w, input int nb = 16,
                       input int gap = 0, input bit take = 1);
    @(posedge i_clk);
    i_host.send(w, nb, gap);
    if (nb == 16 && take) begin
      m_apply(w);
      nfr++;
    end
    repeat (8) @(posedge i_clk);
  endtask

  task automatic pin(input logic v);
    @(posedge i_clk);
    i_load_strobe_n <= v;
    pin_low = !v;
    if (!v) m_load();
    repeat (6) @(posedge i_clk);
  endtask

  task automatic check();
    int ch;
    for (int c = 0; c < 8; c++) `CHK(o_dac_code[c], outr[c])
    `CHK(o_power_down, pd)
    `CHK(o_ref_cfg, rapp)
    axi_rd(dac_pkg::ADDR_STATUS, rd, rsp);
    `CHK(rd, {8'h00, dirty, rapp, pd, mode})
    `CHK(rsp, dac_pkg::RESP_OKAY)
    axi_rd(dac_pkg::ADDR_FRAMES, rd, rsp);
    `CHK(rd, 32'(nfr))
    ch = $urandom_range(7);
    axi_rd(8'(dac_pkg::ADDR_CODE0 + 4 * ch), rd, rsp);
    `CHK(rd, {20'h00000, outr[ch]})
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge i_clk);
    err_count++;
    finish_test();
  end

  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata} = 48'h0;
    i_wstrb = 4'hF;
    i_sys_rst = 1'b1;
    i_load_strobe_n = 1'b1;
    err_count = 0;
    comparisons = 0;
    nfr = 0;
    for (int c = 0; c < 8; c++) begin
      inp[c] = 12'h000;
      outr[c] = 12'h000;
    end
    {dirty, pd, rstg, rapp, pin_low} = 29'h0;
    mode = dac_pkg::LD_HIGH;
    codes = '{dac_pkg::LD_LOW, dac_pkg::LD_RSVD, dac_pkg::LD_HIGH,
              dac_pkg::LD_SINGLE};
    void'($urandom(32'hB4F5));
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    check();
    axi_rd(dac_pkg::ADDR_CONFIG, rd, rsp);
    `CHK(rd, 32'h00000001)
    i_wstrb <= 4'hE;
    axi_wr(dac_pkg::ADDR_CONFIG, 32'h00000000, rsp);
    `CHK(rsp, dac_pkg::RESP_OKAY)
    i_wstrb <= 4'hF;
    axi_rd(dac_pkg::ADDR_CONFIG, rd, rsp);
    `CHK(rd, 32'h00000001)
    axi_rd(8'h10, rd, rsp);
    `CHK({rd, rsp}, {32'h0, dac_pkg::RESP_SLVERR})
    axi_wr(dac_pkg::ADDR_STATUS, 32'hFFFFFFFF, rsp);
    `CHK(rsp, dac_pkg::RESP_SLVERR)
    done("reset");
    for (int c = 0; c < 7; c++) frame({1'b0, 3'(c), 12'($urandom)});
    check();
    pin(1'b0);
    frame({1'b0, 3'h7, 12'($urandom)});
    pin(1'b1);
    check();
    frame({1'b0, 3'h2, 12'($urandom)});
    check();
    pin(1'b0);
    pin(1'b1);
    check();
    done("strobe pin");
    frame({1'b0, 3'h1, 12'($urandom)}, 10);
    frame({1'b1, dac_pkg::CM_PD, 13'h00FF}, 12);
    check();
    @(posedge i_clk);
    i_host.stray(3);
    frame({1'b0, 3'h3, 12'($urandom)}, 16, 20);
    check();
    axi_wr(dac_pkg::ADDR_CONFIG, 32'h00000000, rsp);
    `CHK(rsp, dac_pkg::RESP_OKAY)
    frame({1'b0, 3'h4, 12'($urandom)}, 16, 0, 0);
    axi_wr(dac_pkg::ADDR_CONFIG, 32'h00000001, rsp);
    `CHK(rsp, dac_pkg::RESP_OKAY)
    check();
    done("framing");
    for (int k = 0; k < 4; k++) begin
      frame({1'b0, 3'(k), 12'($urandom)});
      frame({1'b1, dac_pkg::CM_STROBE, 11'($urandom), codes[k]});
      frame({1'b0, 3'(k + 4), 12'($urandom)});
      check();
    end
    done("modes");
    frame({1'b1, dac_pkg::CM_REF, 7'($urandom), 6'($urandom)});
    check();
    frame({1'b1, dac_pkg::CM_STROBE, 11'h000, dac_pkg::LD_SINGLE});
    check();
    frame({1'b1, dac_pkg::CM_PD, 5'($urandom), 8'($urandom)});
    check();
    done("settings");
    frame({1'b0, 3'h5, 12'($urandom)});
    frame({1'b1, dac_pkg::CM_RST, 1'b0, 12'($urandom)});
    check();
    frame({1'b1, dac_pkg::CM_REF, 7'h00, 6'($urandom)});
    frame({1'b1, dac_pkg::CM_STROBE, 11'h000, dac_pkg::LD_LOW});
    frame({1'b1, dac_pkg::CM_RST, 1'b1, 12'($urandom)});
    check();
    done("resets");
    finish_test();
  end
endmodule
